// ===== verification/dds_host_port_mode_decode_tb.sv
/* Self-checking bench for the host port with a host model.
   Assumes pin synchronisers inside the design; seed fixed. */
`timescale 1ns/100ps
module dds_host_port_mode_decode_tb;
  import dhp_pkg::*;
  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic [3:0]  fs = 4'he;
  logic [2:0]  prof = 3'h0;
  logic        strm = 1'b0;
  logic        mlat = 1'b0;
  logic        ase = 1'b1;
  logic        sdi = 1'b0;
  logic        lsb = 1'b0;
  wire  [31:0] pins_w, po_w, oe_w;
  wire         upd_w;
  dhp_core_t   core_w;
  logic [31:0] hf = '0;
  logic [15:0] hp = '0, ha = '0;
  int          num_errors = 0, n_tests = 0, seed = 84401;
  always #5 clk_i = ~clk_i;
  dhp_host_port DUT (.clk_i(clk_i), .rstn_i(rstn_i), .port_i(pins_w),
    .port_o(po_w), .port_oe_o(oe_w), .func_sel_i(fs),
    .profile_select_pins_i(prof), .io_update_i(upd_w),
    .streaming_en_i(strm), .matched_latency_en_i(mlat),
    .amplitude_scale_enable_i(ase), .sdio_input_only_i(sdi),
    .lsb_first_i(lsb), .core_o(core_w));
  dhp_host_model hm (.clk_i(clk_i), .dev_d_i(po_w), .dev_oe_i(oe_w),
    .pins_o(pins_w), .upd_o(upd_w));
  // Holding words after one direct sample
  function automatic void apply(input logic [3:0] c, input logic [31:0] v);
    case (c)
      4'h2: hf = v;
      4'h3: hf = {v[15:0], v[31:16]};
      4'h4: {hp, ha} = v;
      4'h5: {ha, hp} = v;
      4'he, 4'hf: ;
      default: begin
        if (c < 4'ha) hf[31:8] = v[31:8];
        else hf[23:0] = v[31:8];
        case (c[1:0])
          2'b10: ha[15:8] = v[7:0];
          2'b11: hp[15:8] = v[7:0];
          2'b00: ha[7:0] = v[7:0];
          default: hp[7:0] = v[7:0];
        endcase
      end
    endcase
  endfunction
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: exp %h got %h", $time, e, g);
    end
  endtask
  task automatic chk_core;
    dhp_core_t e;
    e = {hf, hp, ase ? ha[11:0] : AMP_FULL};
    n_tests++;
    if (core_w !== e) begin
      num_errors++;
      $display("unexpected at %0t: exp %h got %h", $time, e, core_w);
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #200us;
    num_errors++;
    give_verdict();
  end
  initial begin
    logic [31:0] v, w, q;
    logic [3:0]  c;
    logic [5:0]  a;
    logic [2:0]  p;
    mlat = 1'($random(seed));
    repeat (10) @(posedge clk_i);
    #1 rstn_i = 1'b1;
    hm.step(6);
    strm = 1'b1;
    for (int k = 2; k < 26; k++) begin
      c = (k < 16) ? k[3:0] : 4'(2 + {$random(seed)} % 12);
      mlat = 1'($random(seed));
      if (k >= 16) ase = 1'($random(seed));
      v = $random(seed);
      // Upper amplitude nibble set on purpose
      if (c == 4'h4) v[15:12] = 4'hf;
      hm.drive(v);
      fs = c;
      apply(c, v);
      hm.step(10);
      chk_core();
    end
    ase = 1'b1;
    mlat = 1'b1;
    v = $random(seed);
    w = hf;
    hm.drive(v);
    fs = 4'h2;
    apply(4'h2, v);
    hm.step(4);
    chk(w, core_w.frequency_tuning_word);
    hm.step(2);
    chk_core();
    $display("direct streaming done");
    strm = 1'b0;
    v = $random(seed);
    hm.drive(v);
    fs = 4'h3;
    hm.step(10);
    chk_core();
    apply(4'h3, v);
    hm.upd();
    chk_core();
    v = $random(seed);
    hm.drive(v);
    fs = 4'h5;
    hm.step(10);
    prof = prof + 3'(1 + {$random(seed)} % 7);
    apply(4'h5, v);
    hm.step(10);
    chk_core();
    ase = 1'b0;
    hm.step(10);
    chk_core();
    ase = 1'b1;
    $display("direct held done");
    v = $random(seed);
    hm.drive({v[15:0], 16'h8101});
    fs = FSEL_PARALLEL;
    hm.drive({v[15:0], 16'h8105});
    hm.drive({v[15:0], 16'h8101});
    hm.upd();
    hm.drive(32'h0000_8103);
    hm.step(10);
    chk({16'h0, v[15:0]}, {16'h0, po_w[31:16]});
    hm.drive(32'h0000_8102);
    hm.step(10);
    chk({24'h0, v[15:8]}, {24'h0, po_w[23:16]});
    $display("parallel done");
    hm.drive(32'h0000_0001);
    fs = FSEL_SERIAL;
    lsb = 1'($random(seed));
    sdi = 1'($random(seed));
    hm.step(8);
    v = $random(seed);
    w = $random(seed);
    hm.ser(8'h05, v, 40, lsb, sdi, q);
    hm.upd();
    hm.ser(8'h85, 32'h0, 40, lsb, sdi, q);
    chk(v, q);
    hm.ser(8'h05, w, 40, lsb, sdi, q);
    hm.ser(8'h85, 32'h0, 40, lsb, sdi, q);
    chk(v, q);
    prof = prof + 3'(1 + {$random(seed)} % 7);
    hm.step(10);
    hm.ser(8'h85, 32'h0, 40, lsb, sdi, q);
    chk(w, q);
    v = $random(seed);
    hm.ser(8'h05, v, 20, lsb, sdi, q);
    hm.upd();
    sdi = ~sdi;
    hm.ser(8'hc5, 32'h0, 40, lsb, sdi, q);
    chk({v[31:24], w[23:0]}, q);
    lsb = ~lsb;
    hm.ser(8'h85, 32'h0, 40, lsb, sdi, q);
    chk({v[31:24], w[23:0]}, q);
    p = prof + 3'(1 + {$random(seed)} % 7);
    a = 6'h0b + {2'h0, p, 1'b0};
    w = $random(seed);
    hm.ser({2'b00, a}, w, 40, lsb, sdi, q);
    prof = p;
    hm.step(10);
    hm.ser({2'b10, a}, 32'h0, 40, lsb, sdi, q);
    chk(w, q);
    $display("serial done");
    give_verdict();
  end
endmodule // dds_host_port_mode_decode_tb

// ===== verification/dhp_host_model.sv
/* Host controller model driving the port pins and update strobe.
   Assumes clk_i is the device sync clock; link half period 8 clocks. */
`timescale 1ns/100ps
module dhp_host_model
  import dhp_pkg::*;
(
  // Clock
  input  wire logic        clk_i,
  // Device side of the pins
  input  wire logic [31:0] dev_d_i,
  input  wire logic [31:0] dev_oe_i,
  // Resolved pins and strobe
  output wire logic [31:0] pins_o,
  output logic             upd_o
);
  logic [31:0] drv = 32'h0000_0001;
  initial upd_o = 1'b0;
  // Device wins wherever it drives
  assign pins_o = (dev_oe_i & dev_d_i) | (~dev_oe_i & drv);
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic drive(input logic [31:0] v);
    step(1);
    drv = v;
  endtask
  task automatic upd;
    step(1);
    upd_o = 1'b1;
    step(3);
    upd_o = 1'b0;
    step(10);
  endtask
  task automatic ser(input logic [7:0] ins, input logic [31:0] d,
                     input int nb, input logic lsb, input logic sdo3,
                     output logic [31:0] q);
    int j;
    q = '0;
    drv[4:0] = 5'h00;
    for (int i = 0; i < nb; i++) begin
      j = (i < 8) ? (lsb ? i : 7 - i) : (lsb ? i - 8 : 39 - i);
      // Released line toggles so a stale level never reads right
      if (i < 8 || !ins[7]) drv[PB_SDIO] = (i < 8) ? ins[j] : d[j];
      else drv[PB_SDIO] = ~drv[PB_SDIO];
      step(8);
      if (i >= 8) q[j] = sdo3 ? pins_o[PB_SDO] : pins_o[PB_SDIO];
      drv[PB_SCLK] = 1'b1;
      step(8);
      drv[PB_SCLK] = 1'b0;
    end
    step(8);
    // short transfer ends with an abort pulse
    if (nb < 40) begin
      drv[PB_SYNC] = 1'b1;
      step(8);
      drv[PB_SYNC] = 1'b0;
    end
    drv[PB_CS] = 1'b1;
    step(8);
  endtask
endmodule // dhp_host_model

// ===== verification/dhp_host_port_assertions.sv
/* Checker for the host port, bound to its top ports.
   Assumes pins are held steady several clocks at a time. */
`timescale 1ns/100ps
module dhp_host_port_checker
  import dhp_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic [31:0] port_i,
  input wire logic [31:0] port_oe_o,
  input wire logic [3:0]  func_sel_i,
  input wire logic [2:0]  profile_select_pins_i,
  input wire logic        io_update_i,
  input wire logic        streaming_en_i,
  input wire logic        amplitude_scale_enable_i,
  input dhp_core_t        core_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  wire dir_w = func_sel_i inside {[FSEL_DIR_LO:FSEL_DIR_HI]};
  wire str_w = streaming_en_i && amplitude_scale_enable_i;
  AST_SER_PINS: assert property (
    (func_sel_i == FSEL_SERIAL)[*6] |-> port_oe_o[31:4] == '0)
    else $error("pin driven outside serial set");
  AST_CS_IDLE: assert property (
    (func_sel_i == FSEL_SERIAL && port_i[PB_CS])[*6]
    |-> port_oe_o[3:2] == 2'h0) else $error("data pin driven, cs high");
  AST_DIR_NO_OE: assert property (
    dir_w[*6] |-> port_oe_o == '0) else $error("driven in direct mode");
  AST_PAR_OE: assert property (
    (func_sel_i == FSEL_PARALLEL && port_i[PC_RD] && $stable(port_i))[*6]
    |-> port_oe_o[31:16] == (port_i[PC_WIDE] ? 16'hffff : 16'h00ff))
    else $error("read lanes wrong");
  AST_AMP_OFF: assert property (
    (!amplitude_scale_enable_i)[*8] |-> core_o.amplitude_word == AMP_FULL)
    else $error("amplitude not full scale");
  AST_STREAM_FTW: assert property (
    (str_w && func_sel_i == FSEL_DIR_LO && $stable(port_i))[*8]
    |-> core_o.frequency_tuning_word == port_i) else $error("streamed ftw wrong");
  AST_LOW12: assert property (
    (str_w && func_sel_i == 4'h4 && $stable(port_i))[*8]
    |-> core_o.amplitude_word == port_i[11:0] && core_o.phase_offset_word == port_i[31:16])
    else $error("streamed amp or pow wrong");
  AST_UNUSED: assert property (
    (str_w && func_sel_i inside {4'he, 4'hf})[*8] |-> $stable(core_o))
    else $error("unused code moved core");
  AST_HOLD: assert property (
    (!streaming_en_i && !io_update_i && amplitude_scale_enable_i
     && $stable(profile_select_pins_i))[*8] |-> $stable(core_o))
    else $error("core moved without transfer");
endmodule // dhp_host_port_checker
bind dhp_host_port dhp_host_port_checker u_chk (
  .clk_i(clk_i), .rstn_i(rstn_i), .port_i(port_i),
  .port_oe_o(port_oe_o), .func_sel_i(func_sel_i),
  .profile_select_pins_i(profile_select_pins_i),
  .io_update_i(io_update_i), .streaming_en_i(streaming_en_i),
  .amplitude_scale_enable_i(amplitude_scale_enable_i), .core_o(core_o));

// ===== verilog/dhp_host_port.sv
/*
  Host port of the synthesizer: function-select decode, parallel
  register access, serial register access and direct parameter streaming.
  Assumes clk_i is the sync clock and all pins are asynchronous to it.
*/
`timescale 1ns/100ps
module dhp_host_port
  import dhp_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // Port pins
  input  wire logic [31:0] port_i,
  output logic      [31:0] port_o,
  output logic      [31:0] port_oe_o,
  input  wire logic [3:0]  func_sel_i,
  input  wire logic [2:0]  profile_select_pins_i,
  input  wire logic        io_update_i,
  // Configuration bits
  input  wire logic        streaming_en_i,
  input  wire logic        matched_latency_en_i,
  input  wire logic        amplitude_scale_enable_i,
  input  wire logic        sdio_input_only_i,
  input  wire logic        lsb_first_i,
  // Synthesis core parameters
  output dhp_core_t        core_o
);

  logic        rst_meta_q;
  logic        rst_n_q;
  logic [39:0] pin_m_q;
  logic [39:0] pin_s_q;
  logic        sclk_prev_q;
  logic        wr_prev_q;
  logic        upd_prev_q;
  logic [2:0]  ps_prev_q;
  dhp_ser_t    state_q;
  logic [2:0]  bit_cnt_q;
  logic [1:0]  byte_cnt_q;
  logic [7:0]  shift_q;
  logic [5:0]  addr_q;
  logic [31:0] rd_sh_q;
  logic        tx_bit_q;
  logic [7:0]  buf_q [NUM_BYTES];
  logic [7:0]  act_q [NUM_BYTES];
  dhp_word_t   hold_q;
  dhp_word_t   core_src_q;
  dhp_word_t   st1_q;
  dhp_word_t   st2_q;

  // Direct-mode routing of byte lanes
  function automatic dhp_route_t route(input logic [3:0]  code,
                                       input logic [31:0] p);
    dhp_route_t r;
    r = '0;
    case (code)
      4'h2: begin
        r.w.frequency_tuning_word = p;
        r.be    = 8'hf0;
      end
      4'h3: begin
        r.w.frequency_tuning_word = {p[15:0], p[31:16]};
        r.be    = 8'hf0;
      end
      4'h4: begin
        r.w.phase_offset_word = p[31:16];
        r.w.amplitude_word = p[15:0];
        r.be    = 8'h0f;
      end
      4'h5: begin
        r.w.amplitude_word = p[31:16];
        r.w.phase_offset_word = p[15:0];
        r.be    = 8'h0f;
      end
      default: begin
        if (code >= FSEL_DIR_LO + 4'h4 && code <= FSEL_DIR_HI) begin
          if (code < FSEL_SPLIT) begin
            r.w.frequency_tuning_word[31:8] = p[31:8];
            r.be[7:5]     = 3'h7;
          end else begin
            r.w.frequency_tuning_word[23:0] = p[31:8];
            r.be[6:4]     = 3'h7;
          end
          r.w.phase_offset_word = {p[7:0], p[7:0]};
          r.w.amplitude_word = {p[7:0], p[7:0]};
          // Bit 0 picks phase or amplitude, bit 1 the high byte
          r.be[{code[0], code[1]}] = 1'b1;
        end
      end
    endcase
    return r;
  endfunction

  function automatic dhp_word_t merge(input dhp_word_t  old,
                                      input dhp_route_t r);
    dhp_word_t m;
    m = old;
    for (int k = 0; k < 8; k++) begin
      if (r.be[k]) begin
        m[8*k +: 8] = r.w[8*k +: 8];
      end
    end
    return m;
  endfunction

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // Pins cross into the sync clock through two flops
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pin_m_q <= '0;
      pin_s_q <= '0;
    end else begin
      pin_m_q <= {io_update_i, profile_select_pins_i, func_sel_i, port_i};
      pin_s_q <= pin_m_q;
    end
  end

  wire logic [31:0] pd  = pin_s_q[31:0];
  wire logic [3:0]  fs  = pin_s_q[35:32];
  wire logic [2:0]  ps  = pin_s_q[38:36];
  wire logic        upd = pin_s_q[39];

  // RULE28: continuous decode
  wire logic mode_par = fs == FSEL_PARALLEL;
  wire logic mode_ser = fs == FSEL_SERIAL;
  // RULE4: direct code range
  wire logic mode_dir = fs >= FSEL_DIR_LO && fs <= FSEL_DIR_HI;

  // RULE25: strobe acts on rising edge
  wire logic upd_rise = upd & ~upd_prev_q;
  // RULE18: profile change transfers
  wire logic ps_chg   = ps != ps_prev_q;
  wire logic xfer     = upd_rise | ps_chg;

  // RULE3: serial pins only
  wire logic cs_on     = ~pd[PB_CS];
  wire logic abort     = mode_ser & pd[PB_SYNC];
  // RULE26: chip select suspends
  wire logic ser_en    = mode_ser & cs_on & ~abort;
  wire logic sclk_rise = ser_en & pd[PB_SCLK] & ~sclk_prev_q;
  wire logic sclk_fall = ser_en & ~pd[PB_SCLK] & sclk_prev_q;
  // RULE24: bit order for all bytes
  wire logic [7:0] byte_nx = lsb_first_i ?
                             {pd[PB_SDIO], shift_q[7:1]} :
                             {shift_q[6:0], pd[PB_SDIO]};
  wire logic byte_done  = sclk_rise & (bit_cnt_q == LAST_BIT);
  wire logic instr_done = byte_done & (state_q == SER_INSTR);
  // Highest byte travels first unless LSB first
  wire logic [1:0] lane = lsb_first_i ? byte_cnt_q : ~byte_cnt_q;
  wire logic [7:0] ser_ba = {addr_q, lane};
  wire logic [5:0] rd_reg = byte_nx[5:0];
  wire logic [31:0] rd_word = {act_q[{rd_reg, 2'h3}], act_q[{rd_reg, 2'h2}],
                               act_q[{rd_reg, 2'h1}], act_q[{rd_reg, 2'h0}]};

  // RULE1: parallel field split
  wire logic [7:0] par_ba  = pd[15:8];
  wire logic [7:0] par_bm1 = par_ba - 8'h01;
  wire logic par_wide = pd[PC_WIDE];
  wire logic par_wr   = mode_par & pd[PC_WR] & ~wr_prev_q;
  wire logic par_rd   = mode_par & pd[PC_RD];

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sclk_prev_q <= 1'b0;
      wr_prev_q   <= 1'b0;
      upd_prev_q  <= 1'b0;
      ps_prev_q   <= '0;
    end else begin
      sclk_prev_q <= pd[PB_SCLK];
      wr_prev_q   <= pd[PC_WR];
      upd_prev_q  <= upd;
      ps_prev_q   <= ps;
    end
  end

  // Serial sequencer
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q    <= SER_INSTR;
      bit_cnt_q  <= '0;
      byte_cnt_q <= '0;
      shift_q    <= '0;
      addr_q     <= '0;
    end else if (abort) begin
      // RULE14: abort resets pointer
      state_q    <= SER_INSTR;
      bit_cnt_q  <= '0;
      byte_cnt_q <= '0;
    end else if (sclk_rise) begin
      // RULE12: capture on rising edge
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shift_q   <= byte_nx;
      if (bit_cnt_q == LAST_BIT) begin
        case (state_q)
          // RULE11: instruction then data
          SER_INSTR: begin
            // RULE21: read flag, don't care, address
            addr_q     <= byte_nx[5:0];
            state_q    <= byte_nx[INSTR_RW] ? SER_READ : SER_WRITE;
            byte_cnt_q <= '0;
          end
          SER_WRITE, SER_READ: begin
            byte_cnt_q <= byte_cnt_q + 2'h1;
            // RULE16: back to instruction
            if (byte_cnt_q == LAST_BYTE) begin
              state_q <= SER_INSTR;
            end
          end
          default: state_q <= SER_INSTR;
        endcase
      end
    end
  end

  // RULE19: read shifts out on falling edge
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rd_sh_q  <= '0;
      tx_bit_q <= 1'b0;
    end else if (instr_done && byte_nx[INSTR_RW]) begin
      rd_sh_q <= rd_word;
    end else if (sclk_fall && state_q == SER_READ) begin
      tx_bit_q <= lsb_first_i ? rd_sh_q[0] : rd_sh_q[31];
      rd_sh_q  <= lsb_first_i ? {1'b0, rd_sh_q[31:1]} :
                                {rd_sh_q[30:0], 1'b0};
    end
  end

  // Port buffer; only whole bytes are ever written
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int i = 0; i < NUM_BYTES; i++) begin
        buf_q[i] <= BYTE_RESET;
      end
    end else if (byte_done && state_q == SER_WRITE) begin
      // RULE15: complete bytes kept
      buf_q[ser_ba] <= byte_nx;
    end else if (par_wr) begin
      // RULE2: sixteen or eight data bits
      if (par_wide) begin
        buf_q[par_ba]  <= pd[31:24];
        buf_q[par_bm1] <= pd[23:16];
      end else begin
        buf_q[par_ba] <= pd[23:16];
      end
    end
  end

  // RULE17: buffer to active on strobe
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int i = 0; i < NUM_BYTES; i++) begin
        act_q[i] <= BYTE_RESET;
      end
    end else if (xfer) begin
      act_q <= buf_q;
    end
  end

  // RULE27: lane routing into holding words
  wire dhp_route_t rt     = route(fs, pd);
  wire dhp_word_t  hold_d = mode_dir ? merge(hold_q, rt) : hold_q;

  // RULE7: one sample per sync clock
  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      hold_q     <= '0;
      core_src_q <= '0;
      st1_q      <= '0;
      st2_q      <= '0;
    end else begin
      hold_q <= hold_d;
      // RULE9: streaming bypasses strobe
      if (streaming_en_i) begin
        core_src_q <= hold_d;
      // RULE10: otherwise wait for strobe or profile pin change
      end else if (xfer) begin
        core_src_q <= hold_q;
      end
      st1_q <= core_src_q;
      st2_q <= st1_q;
    end
  end

  // RULE8: pad fast paths when matched
  wire logic [31:0] ftw_sel = matched_latency_en_i ? st2_q.frequency_tuning_word
                                                   : core_src_q.frequency_tuning_word;
  wire logic [15:0] pow_sel = matched_latency_en_i ? st2_q.phase_offset_word : st1_q.phase_offset_word;
  // RULE5: upper amplitude bits dropped
  wire logic [AMP_BITS-1:0] amp_sel = amplitude_scale_enable_i ?
                                      st2_q.amplitude_word[AMP_BITS-1:0] : AMP_FULL;

  // RULE22: two-wire or three-wire reads
  // RULE23: pin mode picks the read pin
  wire logic rd_drive = mode_ser & cs_on & (state_q == SER_READ);
  wire logic sdio_oe  = rd_drive & ~sdio_input_only_i;
  wire logic sdo_oe   = rd_drive & sdio_input_only_i;

  logic [31:0] po_d;
  logic [31:0] poe_d;
  always_comb begin
    po_d  = '0;
    poe_d = '0;
    po_d[PB_SDIO]  = tx_bit_q;
    po_d[PB_SDO]   = tx_bit_q;
    poe_d[PB_SDIO] = sdio_oe;
    poe_d[PB_SDO]  = sdo_oe;
    if (par_rd) begin
      po_d           = '0;
      poe_d          = '0;
      po_d[31:16]    = {act_q[par_ba], act_q[par_bm1]};
      poe_d[23:16]   = 8'hff;
      poe_d[31:24]   = {8{par_wide}};
      if (!par_wide) begin
        po_d[23:16] = act_q[par_ba];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      port_o    <= '0;
      port_oe_o <= '0;
      core_o    <= '0;
    end else begin
      port_o    <= po_d;
      port_oe_o <= poe_d;
      core_o    <= '{frequency_tuning_word: ftw_sel, phase_offset_word: pow_sel, amplitude_word: amp_sel};
    end
  end

endmodule // dhp_host_port

// ===== verilog/dhp_pkg.sv
/*
  Constants, carriers and states for the synthesizer host port block.
  Assumes one sync clock domain; port pins are synchronised in the port.
*/
// Contract
// RULE1: Code 0000: data, address, control bit fields.
// RULE2: Control bit picks 16 or 8 data bits.
// RULE3: Code 0001: only bits 4:0 serve serial.
// RULE4: Codes 0010-1101 direct access; 1110/1111 unused.
// RULE5: Only amplitude bits 11:0 matter.
// RULE6: Host sets amplitude scale enable first.
// RULE7: Direct mode samples port at sync rate.
// RULE8: Matched latency equalises parameter pipeline delays.
// RULE9: Streaming enable bypasses the transfer strobe.
// RULE10: Without streaming, core loads on strobe only; code also loads it on a profile pin change.
// RULE11: Serial cycle: instruction byte, then data phase.
// RULE12: Serial write bits captured on rising clock.
// RULE13: Host sends every byte of the register.
// RULE14: Sync abort ends cycle, resets byte pointer.
// RULE15: Abort keeps whole bytes, drops partial byte.
// RULE16: After a cycle, eight edges form instruction.
// RULE17: Serial data waits in buffer for strobe.
// RULE18: Profile pin change also transfers buffer.
// RULE19: Serial read from active registers, falling edge.
// RULE20: Host sets profile pins to read profiles.
// RULE21: Instruction: bit7 read, bit6 ignored, address.
// RULE22: Two-wire or three-wire serial arrangement.
// RULE23: Pin mode bit: bidirectional or input only.
// RULE24: LSB-first option covers all serial data.
// RULE25: Host strobe pulse exceeds one sync period.
// RULE26: Chip select high: pins idle, cycle suspended.
// RULE27: Direct mode byte lanes routed by code.
// RULE28: Function code decoded continuously.
package dhp_pkg;
  localparam logic [3:0] FSEL_PARALLEL = 4'h0;
  localparam logic [3:0] FSEL_SERIAL   = 4'h1;
  localparam logic [3:0] FSEL_DIR_LO   = 4'h2;
  localparam logic [3:0] FSEL_DIR_HI   = 4'hd;
  localparam logic [3:0] FSEL_SPLIT    = 4'ha;
  // Serial pin positions on the port
  localparam int PB_CS   = 0;
  localparam int PB_SCLK = 1;
  localparam int PB_SDIO = 2;
  localparam int PB_SDO  = 3;
  localparam int PB_SYNC = 4;
  // Parallel control bit positions
  localparam int PC_WIDE = 0;
  localparam int PC_RD   = 1;
  localparam int PC_WR   = 2;
  localparam int INSTR_RW = 7;
  localparam int NUM_BYTES = 256;
  localparam logic [2:0] LAST_BIT  = 3'h7;
  localparam logic [1:0] LAST_BYTE = 2'h3;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [11:0] AMP_FULL = 12'hfff;
  localparam int AMP_BITS = 12;

  typedef struct packed {
    logic [31:0] frequency_tuning_word;
    logic [15:0] phase_offset_word;
    logic [15:0] amplitude_word;
  } dhp_word_t;

  // Byte enables in the same order as the packed word
  typedef struct packed {
    dhp_word_t  w;
    logic [7:0] be;
  } dhp_route_t;

  typedef struct packed {
    logic [31:0]         frequency_tuning_word;
    logic [15:0]         phase_offset_word;
    logic [AMP_BITS-1:0] amplitude_word;
  } dhp_core_t;

  typedef enum logic [1:0] {
    SER_INSTR = 2'b00,
    SER_WRITE = 2'b01,
    SER_READ  = 2'b11
  } dhp_ser_t;
endpackage
